/* rtl/fast_ethernet_4b5b_tx_codec.v */
// 4B/5B transmit coder with framing, line coding and a receive group decoder
`include "fe_codec_regs.vh"
// Operation
// R1: Nibbles 0 to 7 map to 11110,01001,10100,10101,01010,01011,01110,01111.
// R2: Nibbles 8 to F map to 10010,10011,10110,10111,11010,11011,11100,11101.
// R3: First preamble byte of a frame is replaced by J then K.
// R4: Transmit enable falling ends the frame with T then R.
// R5: Idle groups fill every gap until the next frame starts.
// R6: Received J decodes as 0101 only after idle, else receive error.
// R7: Received K decodes as 0101 only after J, else receive error.
// R8: Carrier drops only on T then R; lone T or R gives error.
// R9: Invalid group while data valid raises receive error.
// R10: Control groups inside frame data count as invalid with error.
// R11: Scrambler seed comes from the PHY address.
// R12: Scrambled bits are NRZI coded, then three-level coded.
// R13: Three-level coder steps level on one, holds on zero.
// R14: All groups are serialized and that stream feeds the scrambler.
// R15: Scrambler is 11-stage LFSR, taps 9 and 11, never all zero.
// R16: Groups go out leftmost bit first, one bit per symbol clock.
module fast_ethernet_4b5b_tx_codec (
  // Clock and reset
  input wire clock_i,
  input wire srst_i,
  // Configuration
  input wire [4:0] phy_addr_i,
  // Transmit nibbles from the controller
  input wire tx_en_i,
  input wire [3:0] txd_i,
  output reg tx_take_o,
  // Line
  output wire [1:0] mlt3_o,
  // Received code groups
  input wire rx_group_en_i,
  input wire [4:0] rx_group_i,
  // Receive nibbles to the controller
  output reg [3:0] rxd_o,
  output reg rx_dv_o,
  output reg rx_er_o,
  output reg crs_o
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_K = 4'b0010;
  localparam [3:0] ST_DATA = 4'b0100;
  localparam [3:0] ST_R = 4'b1000;

  reg [3:0] state_q;
  reg [2:0] cnt_q;
  reg [4:0] shift_q;
  reg [4:0] prev_q;
  reg t_pend_q;
  reg [4:0] dec;
  wire load;

  // ------------------------------------------------------------
  // Code tables
  // ------------------------------------------------------------
  function [4:0] encode;
    input [3:0] nib;
    begin
      case (nib)
        4'h0: encode = 5'h1e; // see R1
        4'h1: encode = 5'h09;
        4'h2: encode = 5'h14;
        4'h3: encode = 5'h15;
        4'h4: encode = 5'h0a;
        4'h5: encode = 5'h0b;
        4'h6: encode = 5'h0e;
        4'h7: encode = 5'h0f;
        4'h8: encode = 5'h12; // see R2
        4'h9: encode = 5'h13;
        4'ha: encode = 5'h16;
        4'hb: encode = 5'h17;
        4'hc: encode = 5'h1a;
        4'hd: encode = 5'h1b;
        4'he: encode = 5'h1c;
        default: encode = 5'h1d;
      endcase
    end
  endfunction

  // Top bit flags a data group; control and invalid groups return 0
  always @* begin
    case (rx_group_i)
      5'h1e: dec = 5'h10;
      5'h09: dec = 5'h11;
      5'h14: dec = 5'h12;
      5'h15: dec = 5'h13;
      5'h0a: dec = 5'h14;
      5'h0b: dec = 5'h15;
      5'h0e: dec = 5'h16;
      5'h0f: dec = 5'h17;
      5'h12: dec = 5'h18;
      5'h13: dec = 5'h19;
      5'h16: dec = 5'h1a;
      5'h17: dec = 5'h1b;
      5'h1a: dec = 5'h1c;
      5'h1b: dec = 5'h1d;
      5'h1c: dec = 5'h1e;
      5'h1d: dec = 5'h1f;
      default: dec = 5'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Group divider and framing
  // ------------------------------------------------------------
  assign load = (cnt_q == `GRP_LAST);

  always @(posedge clock_i) begin
    if (srst_i) begin
      cnt_q <= 3'h0;
      tx_take_o <= 1'b0;
      state_q <= ST_IDLE;
      shift_q <= `GRP_IDLE;
    end else begin
      cnt_q <= load ? 3'h0 : cnt_q + 3'h1;
      // Pulse lines up with the cycle the nibble is sampled
      tx_take_o <= (cnt_q == `GRP_TAKE);
      if (load) begin
        case (state_q)
          ST_IDLE: begin
            if (tx_en_i) begin
              shift_q <= `GRP_J; // see R3
              state_q <= ST_K;
            end else begin
              shift_q <= `GRP_IDLE; // see R5
            end
          end
          ST_K: begin
            // Second preamble nibble is consumed by K
            shift_q <= `GRP_K; // see R3
            state_q <= ST_DATA;
          end
          ST_DATA: begin
            if (tx_en_i) begin
              shift_q <= encode(txd_i);
            end else begin
              shift_q <= `GRP_T; // see R4
              state_q <= ST_R;
            end
          end
          ST_R: begin
            // A frame that starts here loses its first nibble; the
            // controller's gap keeps this from happening in practice
            shift_q <= `GRP_R; // see R4
            state_q <= ST_IDLE;
          end
          default: begin
            shift_q <= `GRP_IDLE;
            state_q <= ST_IDLE;
          end
        endcase
      end else begin
        shift_q <= {shift_q[3:0], 1'b0}; // see R16
      end
    end
  end

  // ------------------------------------------------------------
  // Line coding
  // ------------------------------------------------------------
  line_coder u_line (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .phy_addr_i(phy_addr_i),
    .bit_i(shift_q[4]), // see R14
    .mlt3_o(mlt3_o)
  );

  // ------------------------------------------------------------
  // Receive group decoder
  // ------------------------------------------------------------
  always @(posedge clock_i) begin
    if (srst_i) begin
      prev_q <= `GRP_IDLE;
      t_pend_q <= 1'b0;
      rxd_o <= 4'h0;
      rx_dv_o <= 1'b0;
      rx_er_o <= 1'b0;
      crs_o <= 1'b0;
    end else if (rx_group_en_i) begin
      prev_q <= rx_group_i;
      t_pend_q <= 1'b0;
      rx_er_o <= 1'b0;
      if (t_pend_q) begin
        // Verdict on a T waits for the group after it
        if (rx_group_i == `GRP_R) begin
          crs_o <= 1'b0; // see R8
          rx_dv_o <= 1'b0;
        end else begin
          rx_er_o <= 1'b1; // see R8
        end
      end else if (rx_group_i == `GRP_J) begin
        if (prev_q == `GRP_IDLE && !rx_dv_o) begin
          rxd_o <= `NIB_PREAMBLE; // see R6
          crs_o <= 1'b1;
        end else begin
          rx_er_o <= 1'b1; // see R6
        end
      end else if (rx_group_i == `GRP_K) begin
        if (prev_q == `GRP_J && crs_o && !rx_dv_o) begin
          rxd_o <= `NIB_PREAMBLE; // see R7
          rx_dv_o <= 1'b1;
        end else begin
          rx_er_o <= 1'b1; // see R7
        end
      end else if (rx_group_i == `GRP_T) begin
        if (rx_dv_o) begin
          t_pend_q <= 1'b1; // see R8
        end else begin
          rx_er_o <= 1'b1;
        end
      end else if (rx_group_i == `GRP_R) begin
        rx_er_o <= 1'b1; // see R8
      end else if (dec[4]) begin
        rxd_o <= dec[3:0];
      end else if (rx_dv_o) begin
        // Idle and other non-data groups inside a frame are invalid
        rx_er_o <= 1'b1; // see R9 see R10
      end
    end
  end

endmodule // fast_ethernet_4b5b_tx_codec

/* rtl/fe_codec_regs.vh */
// Constants for the 100 Mb/s 4B/5B transmit codec and its receive decoder
`ifndef FE_CODEC_REGS_VH
`define FE_CODEC_REGS_VH
// Control code groups
`define GRP_IDLE 5'h1f
`define GRP_J 5'h18
`define GRP_K 5'h11
`define GRP_T 5'h0d
`define GRP_R 5'h07
// Nibble that stands for each half of the start delimiter
`define NIB_PREAMBLE 4'h5
// Symbol clocks per code group, and the last count of the group divider
`define GRP_BITS 3'h5
`define GRP_LAST 3'h4
`define GRP_TAKE 3'h3
// Low seed bits, kept non-zero so the scrambler never locks up
`define SEED_LOW 6'h2b
// Line levels of the three-level coder
`define MLT_ZERO 2'h0
`define MLT_PLUS 2'h1
`define MLT_MINUS 2'h3
`endif

/* rtl/line_coder.v */
// Scrambler, NRZI coder and three-level coder for the serial bit stream
`include "fe_codec_regs.vh"
module line_coder (
  // Clock and reset
  input wire clock_i,
  input wire srst_i,
  // Seed source
  input wire [4:0] phy_addr_i,
  // Serial code-group bit
  input wire bit_i,
  // Line level
  output reg [1:0] mlt3_o
);

  reg [10:0] lfsr_q;
  reg nrzi_q;
  reg [1:0] phase_q;
  wire scr_bit;
  wire fb;

  // ------------------------------------------------------------
  // Scrambler
  // ------------------------------------------------------------
  assign fb = lfsr_q[10] ^ lfsr_q[8]; // see R15
  assign scr_bit = bit_i ^ lfsr_q[10]; // see R14

  always @(posedge clock_i) begin
    if (srst_i) begin
      // Address picks the seed; low bits keep it non-zero
      lfsr_q <= {phy_addr_i, `SEED_LOW}; // see R11
    end else begin
      lfsr_q <= {lfsr_q[9:0], fb}; // see R15
    end
  end

  // ------------------------------------------------------------
  // NRZI then three-level coding
  // ------------------------------------------------------------
  always @(posedge clock_i) begin
    if (srst_i) begin
      nrzi_q <= 1'b0;
      phase_q <= 2'h0;
      mlt3_o <= `MLT_ZERO;
    end else begin
      // NRZI toggles on each scrambled one
      nrzi_q <= nrzi_q ^ scr_bit; // see R12
      // One NRZI bit steps the line to its next level, zero holds it
      if (nrzi_q) begin // see R13
        phase_q <= phase_q + 2'h1;
        case (phase_q + 2'h1)
          2'h1: mlt3_o <= `MLT_PLUS;
          2'h3: mlt3_o <= `MLT_MINUS;
          default: mlt3_o <= `MLT_ZERO;
        endcase
      end
    end
  end

endmodule // line_coder

/* verification/fe_codec_assertions.sv */
// Port checker for the transmit codec
`include "fe_codec_regs.vh"
module fe_codec_checker (
  // Clock and reset
  input wire clock_i,
  input wire srst_i,
  // Watched ports
  input wire tx_take_o,
  input wire [1:0] mlt3_o,
  input wire rx_group_en_i,
  input wire [4:0] rx_group_i,
  input wire [3:0] rxd_o,
  input wire rx_dv_o,
  input wire rx_er_o,
  input wire crs_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Last group seen, since the pair rules look one group back
  reg [4:0] last_q;
  wire e = rx_group_en_i;
  wire [4:0] g = rx_group_i;
  always @(posedge clock_i) begin
    if (srst_i) last_q <= `GRP_IDLE;
    else if (e) last_q <= g;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_take_gap:
    assert property (tx_take_o |=> !tx_take_o [*4] ##1 tx_take_o)
    else $error("take gap");
  a_mlt_step:
    assert property (mlt3_o != `MLT_ZERO |=>
      mlt3_o == `MLT_ZERO || $stable(mlt3_o)) else $error("mlt step");
  a_j_ok:
    assert property (e && g == `GRP_J && last_q == `GRP_IDLE && !rx_dv_o
      |=> crs_o && rxd_o == 4'h5 && !rx_er_o) else $error("j decode");
  a_j_bad:
    assert property (e && g == `GRP_J && last_q != `GRP_IDLE |=> rx_er_o)
    else $error("stray j");
  a_k_bad:
    assert property (e && g == `GRP_K && last_q != `GRP_J |=> rx_er_o)
    else $error("stray k");
  a_r_bad:
    assert property (e && g == `GRP_R && last_q != `GRP_T |=> rx_er_o)
    else $error("stray r");
  a_tr_end:
    assert property (e && g == `GRP_R && last_q == `GRP_T && rx_dv_o
      |=> !crs_o && !rx_dv_o) else $error("no frame end");
  a_frame_code:
    assert property (e && rx_dv_o && g inside {5'h01, 5'h02, 5'h08,
      `GRP_IDLE} |=> rx_er_o) else $error("bad code passed");
  c_frame_end: cover property (e && g == `GRP_R && last_q == `GRP_T);
  c_rx_err: cover property ($rose(rx_er_o));
  c_minus: cover property (mlt3_o == `MLT_MINUS);
endmodule // fe_codec_checker
bind fast_ethernet_4b5b_tx_codec fe_codec_checker u_chk (.clock_i, .srst_i,
  .tx_take_o, .mlt3_o, .rx_group_en_i, .rx_group_i, .rxd_o, .rx_dv_o,
  .rx_er_o, .crs_o);

/* verification/mac_model.sv */
// Controller model that feeds one frame of nibbles on the take pulses
module mac_model (
  // Clock
  input wire clock_i,
  // Control and handshake
  input wire go_i,
  input wire tx_take_i,
  // Nibble stream
  output logic tx_en_o,
  output logic [3:0] txd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Two preamble nibbles, then 0 to f, then enable drops
  logic [4:0] n_q = 5'h00;
  // One process owns both outputs; change just after a take so the
  // next take sees the new nibble
  initial begin
    tx_en_o = 1'b0;
    txd_o = 4'h0;
    forever begin
      @(posedge clock_i);
      if (tx_take_i && (go_i || n_q != 5'h00)) begin
        #1;
        n_q = (n_q == 5'h12) ? 5'h00 : n_q + 5'h01;
        tx_en_o = (n_q != 5'h00);
        txd_o = (n_q < 5'h03) ? 4'h5 : n_q[3:0] - 4'h3;
      end
    end
  end
endmodule // mac_model

/* verification/fast_ethernet_4b5b_tx_codec_test.sv */
// Testbench for the transmit codec and its group decoder
`include "fe_codec_regs.vh"
module fast_ethernet_4b5b_tx_codec_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0, srst_i = 1'b1, go = 1'b0, rx_group_en_i = 1'b0;
  logic [4:0] phy_addr_i = 5'h0a, rx_group_i = 5'h1f;
  wire tx_en_i, tx_take_o, rx_dv_o, rx_er_o, crs_o;
  wire [3:0] txd_i, rxd_o;
  wire [1:0] mlt3_o;
  int fail_count = 0, tests_run = 0, lk = 0, ph = 0;
  logic st, s, k, stp = 1'b0, col = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [10:0] h = 11'h000, key0 = 11'h000;
  logic [9:0] w = 10'h000;
  logic [4:0] got [$];
  // Groups after the start pair: data 0 to f, end pair, idle
  logic [4:0] exp_t [19] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
    5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d,
    `GRP_T, `GRP_R, `GRP_IDLE};
  // Receive steps: check nibble, nibble, crs dv er, group
  logic [12:0] rx_t [21] = '{13'h001f, 13'h1598, 13'h15d1, 13'h16ce,
    13'h00cd, 13'h0007, 13'h0031, 13'h001f, 13'h1598, 13'h15d1, 13'h00f8,
    13'h00ff, 13'h00e1, 13'h11c9, 13'h00cd, 13'h00e9, 13'h00cd, 13'h0007,
    13'h0027, 13'h0002, 13'h002d};
  fast_ethernet_4b5b_tx_codec u_dut (.clock_i, .srst_i, .phy_addr_i,
    .tx_en_i, .txd_i, .tx_take_o, .mlt3_o, .rx_group_en_i, .rx_group_i,
    .rxd_o, .rx_dv_o, .rx_er_o, .crs_o);
  mac_model u_mac (.clock_i, .go_i(go), .tx_take_i(tx_take_o),
    .tx_en_o(tx_en_i), .txd_o(txd_i));
  always #10 clock_i = ~clock_i;
  // Line monitor: trains the keystream on idles, then rebuilds groups
  always @(negedge clock_i) begin
    st = (mlt3_o !== lvl);
    s = st ^ stp;
    lvl = mlt3_o;
    stp = st;
    k = (lk < 40) ? ~s : h[10] ^ h[8];
    h = {h[9:0], k};
    // Eleven idle bits after release give the key from the seed
    if (lk == 12) key0 = h;
    w = {w[8:0], s ^ k};
    lk = srst_i ? 0 : lk + 1;
    if (col) begin
      ph++;
      if (ph == 5) begin
        got.push_back(w[4:0]);
        ph = 0;
        col = (got.size() < 19);
      end
    end else if (w == 10'h311) begin
      col = 1'b1;
      ph = 0;
    end
  end
  task check(input logic [7:0] e, input logic [7:0] a);
    tests_run++;
    if (a !== e) begin
      fail_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, a);
    end
  endtask
  task check_key(input logic [10:0] e, input logic [10:0] a);
    tests_run++;
    if (a !== e) begin
      fail_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, a);
    end
  endtask
  task test_rx;
    logic [12:0] v;
    for (int i = 0; i < 21; i++) begin
      v = rx_t[i];
      @(posedge clock_i);
      #1 rx_group_en_i = 1'b1;
      rx_group_i = v[4:0];
      @(posedge clock_i);
      #1 rx_group_en_i = 1'b0;
      check(v[7:5], {crs_o, rx_dv_o, rx_er_o});
      if (v[12]) check(v[11:8], rxd_o);
    end
  endtask
  task test_tx;
    go = 1'b1;
    for (int i = 0; i < 50 && tx_en_i !== 1'b1; i++) @(posedge clock_i);
    #1 go = 1'b0;
    for (int i = 0; i < 400 && got.size() < 19; i++) @(posedge clock_i);
    check(8'h13, 8'(got.size()));
    for (int i = 0; i < got.size(); i++)
      check(exp_t[i], got[i]);
  endtask
  // Mid-run reset with a new address: receive outputs clear, take restarts,
  // and the first key bits on the line are the new seed
  task test_seed;
    check_key({phy_addr_i, `SEED_LOW}, key0);
    @(posedge clock_i);
    #1 srst_i = 1'b1;
    phy_addr_i = 5'h13;
    repeat (3) @(posedge clock_i);
    #1 srst_i = 1'b0;
    check(8'h00, {1'b0, crs_o, rx_dv_o, rx_er_o, rxd_o});
    repeat (3) @(posedge clock_i);
    #1 check(8'h00, {7'h00, tx_take_o});
    @(posedge clock_i);
    #1 check(8'h01, {7'h00, tx_take_o});
    repeat (12) @(posedge clock_i);
    #1 check_key({phy_addr_i, `SEED_LOW}, key0);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    #1 srst_i = 1'b0;
    test_rx();
    test_tx();
    test_seed();
    summarize();
  end
  // Run takes well under 1000 cycles
  initial begin
    #50000;
    fail_count++;
    summarize();
  end
endmodule // fast_ethernet_4b5b_tx_codec_test
